// ### verilog/ctrl_method_pkg.sv
// Package with constants, encodings and carrier types of the control method selector
package ctrl_method_pkg;

  // ****************************************
  // Register map (word aligned byte addresses)
  // ****************************************
  localparam logic [3:0] ADDR_CAPACITY   = 4'h0;
  localparam logic [3:0] ADDR_POLES      = 4'h4;
  localparam logic [3:0] ADDR_METHOD     = 4'h8;
  localparam logic [3:0] ADDR_TERM_BASE  = 4'hC;
  localparam logic [3:0] ADDR_TERM_INDEX = 4'h0;

  // ****************************************
  // Setting encodings
  // ****************************************
  localparam logic [15:0] SETTING_VF      = 16'h270F;
  localparam logic [15:0] CAPACITY_MIN    = 16'h0001;
  localparam logic [15:0] CAPACITY_MAX    = 16'h0096;
  localparam logic [15:0] METHOD_ADVANCED = 16'h0014;
  localparam logic [15:0] METHOD_GENERAL  = 16'h001E;
  localparam logic [7:0]  FUNC_VF_SWITCH  = 8'h12;
  localparam logic [7:0]  TERM_FIRST      = 8'hB2;
  localparam int          TERM_COUNT      = 7;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] CAPACITY_RESET  = 16'h270F;
  localparam logic [15:0] POLES_RESET     = 16'h270F;
  localparam logic [15:0] METHOD_RESET    = 16'h0014;
  localparam logic [7:0]  TERM_FUNC_RESET = 8'h00;

  // Control methods
  typedef enum logic [1:0] {
    METHOD_VF,
    METHOD_ADV_FLUX,
    METHOD_GEN_FLUX
  } method_type;

  // Settings carrier
  typedef struct packed {
    logic [15:0] capacity;
    logic [15:0] poles;
    logic [15:0] method;
  } settings_type;

  // Status carrier
  typedef struct packed {
    method_type method;
    logic       second_active;
    logic       switch_mapped;
  } status_type;

endpackage : ctrl_method_pkg

// ### verilog/method_decode.sv
// Combinational decode of settings into the configured control method
`timescale 1ns/1ps
module method_decode (
  input  ctrl_method_pkg::settings_type settings,
  output ctrl_method_pkg::method_type   method
);

  // *******************
  // Method table
  // *******************
  // Either motor setting reserved forces the constant ratio mode
  always_comb begin
    if (settings.capacity == ctrl_method_pkg::SETTING_VF ||
        settings.poles == ctrl_method_pkg::SETTING_VF) begin
      method = ctrl_method_pkg::METHOD_VF;
    end else if (settings.method == ctrl_method_pkg::METHOD_GENERAL) begin
      method = ctrl_method_pkg::METHOD_GEN_FLUX;
    end else begin
      method = ctrl_method_pkg::METHOD_ADV_FLUX;
    end
  end

endmodule : method_decode

// ### verilog/setting_check.sv
// Range check of written setting values
`timescale 1ns/1ps
module setting_check (
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] value,
  output logic             accept
);

  // *******************
  // Legal values
  // *******************
  // Capacity in 0.1 kW steps, poles even 2..10, code 20 or 30
  always_comb begin
    case (addr)
      ctrl_method_pkg::ADDR_CAPACITY: begin
        accept = value == ctrl_method_pkg::SETTING_VF ||
                 (value >= ctrl_method_pkg::CAPACITY_MIN &&
                  value <= ctrl_method_pkg::CAPACITY_MAX);
      end
      ctrl_method_pkg::ADDR_POLES: begin
        accept = value == ctrl_method_pkg::SETTING_VF ||
                 (value >= 16'h0002 && value <= 16'h000A && !value[0]);
      end
      ctrl_method_pkg::ADDR_METHOD: begin
        accept = value == ctrl_method_pkg::METHOD_ADVANCED ||
                 value == ctrl_method_pkg::METHOD_GENERAL;
      end
      default: begin
        accept = 1'b1;
      end
    endcase
  end

endmodule : setting_check

// ### verilog/method_selector.sv
// Control method selector with Avalon-MM settings registers
//
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps

// How it works
// - After reset all settings hold initial values, giving constant ratio mode
// - Capacity takes 0.1 to 15 kW in tenths, or 9999 for ratio mode
// - Pole count takes 2, 4, 6, 8, 10, or 9999 for ratio mode
// - Both motor settings valid: code 20 advanced flux, code 30 general flux
// - Any motor setting at 9999 forces ratio mode whatever the code
// - Switchover input replaces a flux method by ratio mode
// - Switchover works only if a terminal function setting holds code 18
// - Switchover into ratio mode also activates second function set
// - While running the method is frozen; switchover only selects second set
// - Second function select input validates the whole second parameter set
module method_selector #(
  parameter int TERMS = ctrl_method_pkg::TERM_COUNT
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  input  wire logic [3:0]              address,
  input  wire logic                    read,
  input  wire logic                    write,
  input  wire logic [31:0]             writedata,
  output logic      [31:0]             readdata,
  output logic                         waitrequest,
  input  wire logic [TERMS-1:0]        terminal_in,
  input  wire logic                    second_function_select,
  input  wire logic                    running,
  output ctrl_method_pkg::method_type  active_method,
  output logic                         second_function_active,
  output logic                         write_rejected
);

  // ****************************************
  // Settings registers
  // ****************************************
  ctrl_method_pkg::settings_type settings_r;
  ctrl_method_pkg::settings_type settings_nxt;
  logic [7:0]                    term_func_r   [TERMS];
  logic [7:0]                    term_func_nxt [TERMS];
  logic                          reject_r;
  logic                          reject_nxt;
  logic                          accept;
  logic [3:0]                    term_index;
  logic                          term_hit;

  // Terminal 0 register follows the three settings in one word; the 4-bit address leaves no word for the other terminals
  always_comb begin
    term_index = address - ctrl_method_pkg::ADDR_TERM_BASE;
    term_hit   = address >= ctrl_method_pkg::ADDR_TERM_BASE && term_index[1:0] == 2'b00 &&
                 32'(term_index[3:2]) < TERMS;
  end

  setting_check check_inst (
    .addr   (address),
    .value  (writedata[15:0]),
    .accept (accept)
  );

  // Write path: out-of-range values are dropped and flagged
  always_comb begin
    settings_nxt = settings_r;
    reject_nxt   = reject_r;
    for (int i = 0; i < TERMS; i++) begin
      term_func_nxt[i] = term_func_r[i];
    end
    if (write) begin
      reject_nxt = !accept;
      case (address)
        ctrl_method_pkg::ADDR_CAPACITY: begin
          if (accept) settings_nxt.capacity = writedata[15:0];
        end
        ctrl_method_pkg::ADDR_POLES: begin
          if (accept) settings_nxt.poles = writedata[15:0];
        end
        ctrl_method_pkg::ADDR_METHOD: begin
          if (accept) settings_nxt.method = writedata[15:0];
        end
        default: begin
          if (term_hit) begin
            term_func_nxt[term_index[3:2]] = writedata[7:0];
          end
        end
      endcase
    end
  end

  // Initial values restore ratio mode
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      settings_r.capacity <= ctrl_method_pkg::CAPACITY_RESET;
      settings_r.poles    <= ctrl_method_pkg::POLES_RESET;
      settings_r.method   <= ctrl_method_pkg::METHOD_RESET;
      reject_r            <= 1'b0;
      for (int i = 0; i < TERMS; i++) begin
        term_func_r[i] <= ctrl_method_pkg::TERM_FUNC_RESET;
      end
    end else begin
      settings_r <= settings_nxt;
      reject_r   <= reject_nxt;
      for (int i = 0; i < TERMS; i++) begin
        term_func_r[i] <= term_func_nxt[i];
      end
    end
  end

  // ****************************************
  // Method selection
  // ****************************************
  ctrl_method_pkg::method_type configured;
  ctrl_method_pkg::method_type method_r;
  ctrl_method_pkg::method_type method_nxt;
  logic                        second_r;
  logic                        second_nxt;
  logic                        switch_req;
  logic                        switch_mapped;

  method_decode decode_inst (
    .settings (settings_r),
    .method   (configured)
  );

  // Switchover is seen only on terminals assigned its function code
  always_comb begin
    switch_req    = 1'b0;
    switch_mapped = 1'b0;
    for (int i = 0; i < TERMS; i++) begin
      if (term_func_r[i] == ctrl_method_pkg::FUNC_VF_SWITCH) begin
        switch_mapped = 1'b1;
        switch_req    = switch_req | terminal_in[i];
      end
    end
  end

  // Method is frozen while running so the drive never jumps modes mid-output
  always_comb begin
    method_nxt = method_r;
    if (!running) begin
      if (switch_req) begin
        method_nxt = ctrl_method_pkg::METHOD_VF;
      end else begin
        method_nxt = configured;
      end
    end
    second_nxt = second_function_select | switch_req;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      method_r <= ctrl_method_pkg::METHOD_VF;
      second_r <= 1'b0;
    end else begin
      method_r <= method_nxt;
      second_r <= second_nxt;
    end
  end

  // ****************************************
  // Bus answer
  // ****************************************
  ctrl_method_pkg::status_type status;
  logic [31:0]                 read_nxt;
  logic [31:0]                 readdata_r;
  logic                        ack_r;

  // Status word shares the method register address from bit 16 up
  always_comb begin
    status.method        = method_r;
    status.second_active = second_r;
    status.switch_mapped = switch_mapped;
    read_nxt             = 32'h0000_0000;
    case (address)
      ctrl_method_pkg::ADDR_CAPACITY: read_nxt = {16'h0000, settings_r.capacity};
      ctrl_method_pkg::ADDR_POLES:    read_nxt = {16'h0000, settings_r.poles};
      ctrl_method_pkg::ADDR_METHOD:   read_nxt = {12'h000, status, settings_r.method};
      default: begin
        if (term_hit) read_nxt = {24'h00_0000, term_func_r[term_index[3:2]]};
      end
    endcase
  end

  // One wait cycle per access gives registered read data
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack_r      <= 1'b0;
      readdata_r <= 32'h0000_0000;
    end else begin
      ack_r      <= (read | write) & !ack_r;
      readdata_r <= read_nxt;
    end
  end

  assign waitrequest            = (read | write) & !ack_r;
  assign readdata               = readdata_r;
  assign active_method          = method_r;
  assign second_function_active = second_r;
  assign write_rejected         = reject_r;

endmodule : method_selector

// ### bench/terminal_drive.sv
// Model of the controller that drives the inverter terminals
`timescale 1ns/1ps
module terminal_drive (
  input  wire logic       switch_cmd,
  input  wire logic       select_cmd,
  input  wire logic       run_cmd,
  input  wire logic       tuned,
  output logic      [6:0] terminal_in,
  output logic            second_function_select,
  output logic            running
);
  // Switchover sits on terminal 0; the rest stay low
  assign terminal_in = {6'h00, switch_cmd};
  assign second_function_select = select_cmd;
  // No run before the motor data self-setting is done
  assign running = run_cmd && tuned;
endmodule : terminal_drive

// ### bench/method_selector_sva.sv
// Port checker of the control method selector
`timescale 1ns/1ps
module method_selector_sva #(
  parameter int TERMS = 7
) (
  input wire logic                       clk_sys,
  input wire logic                       rst,
  input wire logic                       read,
  input wire logic                       write,
  input wire logic                       waitrequest,
  input wire logic [TERMS-1:0]           terminal_in,
  input wire logic                       second_function_select,
  input wire logic                       running,
  input wire ctrl_method_pkg::method_type active_method,
  input wire logic                       second_function_active,
  input wire logic                       write_rejected
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // First cycle of an access
  sequence acc_start;
    (read || write) && waitrequest;
  endsequence
  a_reset_vf:
    assert property ($fell(rst) |-> active_method == ctrl_method_pkg::METHOD_VF)
    else $error("method not ratio after reset");
  a_wait_first:
    assert property ($rose(read || write) |-> waitrequest) else $error("no wait cycle");
  a_wait_one:
    assert property (acc_start |=> !waitrequest) else $error("wait too long");
  a_idle_ready:
    assert property (!read && !write |-> !waitrequest) else $error("wait while idle");
  a_freeze_run:
    assert property (running |=> $stable(active_method)) else $error("method moved while running");
  a_second_sel:
    assert property (second_function_select |=> second_function_active)
    else $error("second set not active");
  a_second_off:
    assert property (!second_function_select && terminal_in == '0 |=> !second_function_active)
    else $error("second set active without cause");
  a_reject_hold:
    assert property (!write |=> $stable(write_rejected)) else $error("reject flag moved");
endmodule : method_selector_sva

bind method_selector method_selector_sva #(.TERMS(TERMS)) method_selector_sva_inst (
  .clk_sys(clk_sys), .rst(rst), .read(read), .write(write), .waitrequest(waitrequest),
  .terminal_in(terminal_in), .second_function_select(second_function_select),
  .running(running), .active_method(active_method),
  .second_function_active(second_function_active), .write_rejected(write_rejected));

// ### bench/method_selector_tb_top.sv
// Testbench of the control method selector
`timescale 1ns/1ps
module method_selector_tb_top;
  logic clk_sys = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0;
  logic sw = 1'b0, sel = 1'b0, run = 1'b0, tuned = 1'b0;
  logic [3:0] address = 4'h0;
  logic [31:0] writedata = 32'h0, readdata, q;
  logic waitrequest, second_function_select, running, second_function_active, write_rejected;
  logic [6:0] terminal_in;
  ctrl_method_pkg::method_type active_method;
  int err_total = 0;
  int checks_done = 0;
  localparam logic [31:0] VF = 32'(ctrl_method_pkg::METHOD_VF);
  localparam logic [31:0] ADV = 32'(ctrl_method_pkg::METHOD_ADV_FLUX);
  localparam logic [31:0] GEN = 32'(ctrl_method_pkg::METHOD_GEN_FLUX);
  logic [15:0] pl [5] = '{16'h0002, 16'h0004, 16'h0006, 16'h0008, 16'h000A};
  always #4 clk_sys = ~clk_sys;
  method_selector #(.TERMS(7)) method_selector_inst (.clk_sys(clk_sys), .rst(rst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .terminal_in(terminal_in),
    .second_function_select(second_function_select), .running(running),
    .active_method(active_method), .second_function_active(second_function_active),
    .write_rejected(write_rejected));
  terminal_drive terminal_drive_inst (.switch_cmd(sw), .select_cmd(sel), .run_cmd(run),
    .tuned(tuned), .terminal_in(terminal_in),
    .second_function_select(second_function_select), .running(running));
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Holds the request until a rising edge samples waitrequest low; data taken at that edge
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    write <= wr; read <= !wr; address <= a; writedata <= d;
    @(posedge clk_sys);
    while (waitrequest) @(posedge clk_sys);
    q = readdata;
    write <= 1'b0; read <= 1'b0;
  endtask : bus
  task wr(input logic [3:0] a, input logic [15:0] d); bus(1'b1, a, {16'h0, d}); endtask : wr
  task rd(input logic [3:0] a, input logic [15:0] e);
    bus(1'b0, a, 32'h0);
    chk("readdata", {16'h0, e}, {16'h0, q[15:0]});
  endtask : rd
  task pins(input logic s, input logic l, input logic r);
    @(posedge clk_sys);
    sw <= s; sel <= l; run <= r;
  endtask : pins
  // Registered outputs need a few edges to show a change
  task cm(input logic [31:0] e, input logic [31:0] s);
    repeat (3) @(negedge clk_sys);
    chk("method", e, {30'h0, active_method});
    chk("second", s, {31'h0, second_function_active});
  endtask : cm
  // Flag is registered, so look at it mid-cycle once it has settled
  task rj(input logic e);
    @(negedge clk_sys);
    chk("rejected", {31'h0, e}, {31'h0, write_rejected});
  endtask : rj
  task end_of_test;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    tuned <= 1'b1;
    cm(VF, 0);
    rd(ctrl_method_pkg::ADDR_CAPACITY, 16'h270F);
    rd(ctrl_method_pkg::ADDR_POLES, 16'h270F);
    rd(ctrl_method_pkg::ADDR_METHOD, 16'h0014);
    wr(ctrl_method_pkg::ADDR_CAPACITY, 16'h0096);
    wr(ctrl_method_pkg::ADDR_POLES, 16'h0004);
    cm(ADV, 0);
    wr(ctrl_method_pkg::ADDR_CAPACITY, 16'h0097);
    rj(1'b1);
    wr(ctrl_method_pkg::ADDR_POLES, 16'h0003);
    rj(1'b1);
    wr(ctrl_method_pkg::ADDR_METHOD, 16'h0019);
    rj(1'b1);
    rd(ctrl_method_pkg::ADDR_CAPACITY, 16'h0096);
    wr(ctrl_method_pkg::ADDR_METHOD, 16'h001E);
    rj(1'b0);
    cm(GEN, 0);
    wr(ctrl_method_pkg::ADDR_METHOD, 16'h0014);
    wr(ctrl_method_pkg::ADDR_CAPACITY, 16'h0001);
    rj(1'b0);
    foreach (pl[i]) begin
      wr(ctrl_method_pkg::ADDR_POLES, pl[i]);
      rj(1'b0);
    end
    cm(ADV, 0);
    wr(ctrl_method_pkg::ADDR_CAPACITY, 16'h270F);
    cm(VF, 0);
    wr(ctrl_method_pkg::ADDR_CAPACITY, 16'h0096);
    pins(1'b1, 1'b0, 1'b0);
    cm(ADV, 0);
    wr(ctrl_method_pkg::ADDR_TERM_BASE, 16'h0012);
    rd(ctrl_method_pkg::ADDR_TERM_BASE, 16'h0012);
    cm(VF, 1);
    bus(1'b0, ctrl_method_pkg::ADDR_METHOD, 32'h0000_0000);
    chk("status", 32'h0003_0014, q);
    pins(1'b0, 1'b0, 1'b1);
    cm(VF, 0);
    pins(1'b0, 1'b0, 1'b0);
    cm(ADV, 0);
    pins(1'b1, 1'b0, 1'b1);
    cm(ADV, 1);
    pins(1'b0, 1'b1, 1'b0);
    cm(ADV, 1);
    wr(ctrl_method_pkg::ADDR_POLES, 16'h270F);
    pins(1'b1, 1'b0, 1'b0);
    cm(VF, 1);
    rd(4'h2, 16'h0000);
    end_of_test;
  end
  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_total++;
    end_of_test;
  end
endmodule : method_selector_tb_top
